// ===== inc/spim_pkg.sv
// constants shared by the serial port interrupt mask block
// How it works
// RQ1 - overrun mask bit 10, resets zero
// RQ2 - break error mask bit 9, resets zero
// RQ3 - parity error mask bit 8, resets zero
// RQ4 - framing error mask bit 7, resets zero
// RQ5 - receive timeout mask bit 6, resets zero
// RQ6 - transmit mask bit 5, resets zero
// RQ7 - receive mask bit 4, resets zero
// RQ8 - reads return stored mask, no side effects
// RQ9 - bits 31:11 and 3:0 read zero
// RQ10 - software preserves reserved bits on writeback
// RQ11 - cleared mask blocks raw interrupt, raw kept
// RQ12 - one output: any raw and mask set
package spim_pkg;
   // register byte offsets
   localparam logic [11:0] SPIM_MASK_OFFSET   = 12'h038;  // interrupt_mask
   localparam logic [11:0] SPIM_RAW_OFFSET    = 12'h03C;  // raw event status
   localparam logic [11:0] SPIM_MASKED_OFFSET = 12'h040;  // masked status
   localparam logic [11:0] SPIM_CLEAR_OFFSET  = 12'h044;  // write-one-to-clear
   // field positions
   localparam int SPIM_RX_BIT  = 4;
   localparam int SPIM_TX_BIT  = 5;
   localparam int SPIM_RT_BIT  = 6;
   localparam int SPIM_FE_BIT  = 7;
   localparam int SPIM_PE_BIT  = 8;
   localparam int SPIM_BE_BIT  = 9;
   localparam int SPIM_OE_BIT  = 10;
   localparam int SPIM_LSB     = SPIM_RX_BIT;
   localparam int SPIM_NSRC    = 7;
   // reset value of every register
   localparam logic [31:0] SPIM_RESET_VAL = 32'h0000_0000;
endpackage

// ===== rtl/spim_src_bit.sv
// one interrupt source: sticky raw flag and its mask bit
`timescale 1ns/100ps
module spim_src_bit (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic event_in,    // one-cycle or level event
   input  wire logic mask_we,     // mask write strobe
   input  wire logic mask_wdata,  // new mask value
   input  wire logic clear_in,    // software clear strobe
   output logic      raw_out,     // sticky raw status
   output logic      mask_out,    // stored mask
   output logic      masked_out   // raw gated by mask
);
   // mask bit, read/write, resets to zero
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mask_out <= 1'b0;
      end else if (mask_we) begin
         mask_out <= mask_wdata;
      end
   end

   // raw flag recorded whatever the mask; set wins over clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         raw_out <= 1'b0;
      end else if (event_in) begin
         raw_out <= 1'b1;  // RQ11
      end else if (clear_in) begin
         raw_out <= 1'b0;
      end
   end

   // gate: a cleared mask keeps the source off the controller
   assign masked_out = raw_out & mask_out;  // RQ11
endmodule // spim_src_bit

// ===== rtl/spim_top.sv
// interrupt mask block of the serial port with apb slave
`timescale 1ns/100ps
module spim_top
   import spim_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        rx_event,      // receive
   input  wire logic        tx_event,      // transmit
   input  wire logic        rt_event,      // receive time-out
   input  wire logic        fe_event,      // framing error
   input  wire logic        pe_event,      // parity error
   input  wire logic        be_event,      // break error
   input  wire logic        oe_event,      // overrun error
   output logic             irq            // level to interrupt controller
);
   logic [SPIM_NSRC-1:0] ev_vec;      // events in bit order from bit 4
   logic [SPIM_NSRC-1:0] raw_vec;     // sticky raw flags
   logic [SPIM_NSRC-1:0] mask_vec;    // stored masks
   logic [SPIM_NSRC-1:0] masked_vec;  // raw and mask
   logic                 wr_acc;      // write access phase
   logic                 rd_acc;      // read setup phase
   logic                 mask_we;     // mask write strobe
   logic                 clr_we;      // clear write strobe
   logic                 addr_ok;     // mapped address
   logic [31:0]          rd_mux;      // read data before the flop

   // same-clock sources, no synchroniser needed
   assign ev_vec = {oe_event, be_event, pe_event, fe_event,
                    rt_event, tx_event, rx_event};

   // apb decode; zero wait states
   assign wr_acc  = psel & penable & pwrite;
   assign rd_acc  = psel & ~penable & ~pwrite;
   assign mask_we = wr_acc & (paddr == SPIM_MASK_OFFSET);
   assign clr_we  = wr_acc & (paddr == SPIM_CLEAR_OFFSET);
   assign addr_ok = (paddr == SPIM_MASK_OFFSET) | (paddr == SPIM_RAW_OFFSET) |
                    (paddr == SPIM_MASKED_OFFSET) | (paddr == SPIM_CLEAR_OFFSET);
   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~addr_ok;  // unmapped answers with error

   // one cell per source, bits 10 down to 4
   genvar gi;
   generate
      for (gi = 0; gi < SPIM_NSRC; gi++) begin : g_src
         spim_src_bit u_bit (
            .pclk       (pclk),
            .presetn    (presetn),
            .event_in   (ev_vec[gi]),
            .mask_we    (mask_we),           // RQ1 RQ2 RQ3 RQ4 RQ5 RQ6 RQ7
            .mask_wdata (pwdata[SPIM_LSB+gi]),
            .clear_in   (clr_we & pwdata[SPIM_LSB+gi]),
            .raw_out    (raw_vec[gi]),
            .mask_out   (mask_vec[gi]),
            .masked_out (masked_vec[gi])
         );
      end
   endgenerate

   // read mux; reserved bits stay zero, reads change nothing
   always_comb begin
      rd_mux = SPIM_RESET_VAL;  // RQ9
      case (paddr)
         SPIM_MASK_OFFSET:   rd_mux[SPIM_OE_BIT:SPIM_RX_BIT] = mask_vec;    // RQ8
         SPIM_RAW_OFFSET:    rd_mux[SPIM_OE_BIT:SPIM_RX_BIT] = raw_vec;
         SPIM_MASKED_OFFSET: rd_mux[SPIM_OE_BIT:SPIM_RX_BIT] = masked_vec;
         default:            rd_mux = SPIM_RESET_VAL;
      endcase
   end

   // read data captured in setup, stable through access phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= SPIM_RESET_VAL;
      end else if (rd_acc) begin
         prdata <= rd_mux;  // RQ8
      end
   end

   // registered level interrupt; lags masked status by one cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |masked_vec;  // RQ12
      end
   end
endmodule // spim_top

// ===== dv/spim_props.sv
// port checker for the serial port interrupt mask block
`timescale 1ns/100ps
module spim_props
   import spim_pkg::*;
(input wire logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata);
   logic hit;  // address decodes to a register
   assign hit = paddr inside {SPIM_MASK_OFFSET, SPIM_RAW_OFFSET, SPIM_MASKED_OFFSET,
      SPIM_CLEAR_OFFSET};
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   rdy_a: assert property (pready) else $error("wait state seen");
   err_a: assert property (psel && penable && !hit |-> pslverr) else $error("no error");
   ok_a: assert property (psel && penable && hit |-> !pslverr) else $error("false error");
   idle_a: assert property (!(psel && penable) |-> !pslverr) else $error("stray error");
   rsv_bits_a: assert property (psel && !penable && !pwrite && paddr == SPIM_MASK_OFFSET |=>
      prdata[31:11] == 0 && prdata[3:0] == 0) else $error("reserved bit set");
   zero_rd_a: assert property (psel && !penable && !pwrite && !hit |=> prdata == 0)
      else $error("unmapped read not zero");
   rd_hold_a: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
      else $error("read data moved");
   irq_fall_a: assert property ($fell(irq) |-> $past(psel && penable && pwrite, 2))
      else $error("irq fell alone");
   cover property ($rose(irq));
   cover property ($fell(irq));
   cover property (psel && penable && pslverr);
endmodule // spim_props

// ===== dv/spim_ctl_model.sv
// interrupt controller model: counts requests on the level line
`timescale 1ns/100ps
module spim_ctl_model (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic irq,
   output int        n_irq
);
   logic irq_reg;  // last level, to find new requests
   // a request is one rising level; the line stays high until software acts
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_reg <= 1'b0;
         n_irq   <= 0;
      end else begin
         irq_reg <= irq;
         if (irq && !irq_reg) n_irq <= n_irq + 1;
      end
   end
endmodule // spim_ctl_model

// ===== dv/tb_spim_top.sv
// self-checking testbench for the serial port interrupt mask block
`timescale 1ns/100ps
module tb_spim_top;
   import spim_pkg::*;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, irq, er;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, rd;
   logic [6:0] ev = 0;  // sources, receive at bit 0
   int n_errors = 0, samples_checked = 0, cyc = 0, n_irq;
   spim_top dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .rx_event(ev[0]), .tx_event(ev[1]), .rt_event(ev[2]),
      .fe_event(ev[3]), .pe_event(ev[4]), .be_event(ev[5]), .oe_event(ev[6]), .irq);
   spim_ctl_model ctl_u (.pclk, .presetn, .irq, .n_irq);
   initial forever #25 pclk = ~pclk;
   task chk(input string nm, input logic [31:0] seen, exp);
      samples_checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // one apb transfer; holds the request until pready is sampled high
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
      @(posedge pclk) penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      {psel, penable} <= 2'b00;
   endtask
   task finish_test;
      $display("errors %0d checks %0d", n_errors, samples_checked);
      if (n_errors == 0 && samples_checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // cut a hang short
   always @(posedge pclk) if (++cyc == 3000) begin
      n_errors++;
      finish_test;
   end
   // each source alone: forwarded when unmasked, blocked but kept when masked
   task t_src;
      logic [31:0] b;
      for (int i = 0; i < 7; i++) begin
         b = 32'h0000_0010 << i;
         apb(1'b1, SPIM_MASK_OFFSET, b);
         ev <= b[10:4];
         @(posedge pclk) ev <= '0;
         repeat (2) @(posedge pclk);
         chk("irq", irq, 1'b1);
         apb(1'b0, SPIM_MASKED_OFFSET, '0);
         chk("masked", rd, b);
         apb(1'b1, SPIM_MASK_OFFSET, '0);
         repeat (2) @(posedge pclk);
         chk("irq off", irq, 1'b0);
         apb(1'b0, SPIM_RAW_OFFSET, '0);
         chk("raw", rd, b);
         apb(1'b1, SPIM_CLEAR_OFFSET, b);
      end
      chk("requests", n_irq, 7);
   endtask
   // reset value, then all ones: only the seven mask bits stick
   task t_rsv;
      apb(1'b0, SPIM_MASK_OFFSET, '0);
      chk("mask reset", rd, SPIM_RESET_VAL);
      apb(1'b1, SPIM_MASK_OFFSET, 32'hFFFF_FFFF);
      apb(1'b0, SPIM_MASK_OFFSET, '0);
      chk("mask", rd, 32'h0000_07F0);
      apb(1'b0, SPIM_MASK_OFFSET, '0);
      chk("mask again", rd, 32'h0000_07F0);
      apb(1'b1, 12'h048, 32'hFFFF_FFFF);
      chk("slverr", er, 1'b1);
      apb(1'b0, SPIM_MASK_OFFSET, '0);
      chk("mask kept", rd, 32'h0000_07F0);
      apb(1'b1, SPIM_MASK_OFFSET, rd & 32'hFFFF_FFEF);
      apb(1'b0, SPIM_MASK_OFFSET, '0);
      chk("mask rmw", rd, 32'h0000_07E0);
   endtask
   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      t_rsv;
      apb(1'b1, SPIM_MASK_OFFSET, '0);
      t_src;
      finish_test;
   end
endmodule // tb_spim_top
bind spim_top spim_props u_props (.*);
